// ===== design/host_bus_port_daisy_chain.sv
// Host bus port with wait/ready handshake, bus modes, interrupt daisy chain,
// fly-by acknowledge pins and serial data pins for two channels.
// Assumes all pins are synchronous to clk; the register core answers on reg_ack.
//
// Operation
// - Wait/ready flags read, write and vector readiness
// - Channel select at config picks wait or ready
// - 16-bit non-multiplexed: all lines data, pointer addressing
// - Pointer modes: host loads pointer, device uses it
// - 8-bit pointer mode: low byte data, upper ignored
// - 8-bit separate address: address on upper lines
// - 16-bit multiplexed: latch low-byte address, 16-bit data
// - 8-bit multiplexed separate address: low byte data
// - Per-channel driven active-low interrupt request
// - Chain enable out low on block conditions
// - Transmit acknowledge strobes fly-by write or bit I/O
// - Receive acknowledge strobes fly-by read or bit I/O
// - Serial transmit output with three-state enable
// - Serial receive from dedicated input
// - First write after reset is the bus configuration
// - Channel select latched at configuration write
`timescale 1ns/1ps

module host_bus_port_daisy_chain
  import host_port_pkg::*;
(
  input  wire logic                     clk,          // 100 MHz clock
  input  wire logic                     srst,         // Synchronous reset, active high
  input  wire host_ctrl_t               host_ctrl,    // Host strobes and selects
  input  wire logic [DATA_W-1:0]        host_bus_in,  // Level on the address/data lines
  output logic      [DATA_W-1:0]        host_bus_out, // Read data driven on the lines
  output logic      [1:0]               host_bus_oe,  // Per byte lane drive enable
  output logic                          wait_rdy_n,   // Wait or ready, active low
  output core_req_t                     core_req,     // Request to the register core
  input  wire logic                     reg_ack,      // Core has finished the request
  input  wire logic [DATA_W-1:0]        reg_rdata,    // Read data or vector from core
  input  wire chan_in_t  [NUM_CH-1:0]   chan_in,      // Per-channel inputs
  output chan_out_t      [NUM_CH-1:0]   chan_out      // Per-channel outputs
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    port_state_t               st;
    logic                      cfg_done;   // Configuration write seen
    bus_mode_t                 mode;
    logic                      wait_sense; // High: wait, low: ready
    logic [ADDR_W-1:0]         ptr;        // Internal register pointer
    logic [ADDR_W-1:0]         mux_addr;   // Address latched on strobe rise
    logic                      mux_cs;     // Chip select latched on strobe rise
    logic                      as_prev;
    logic                      is_read;    // Current cycle reads
    logic [1:0]                be;
    core_req_t                 req;
    logic [DATA_W-1:0]         bus_out;
    logic [1:0]                bus_oe;
    logic                      wait_rdy_n;
    logic [NUM_CH-1:0]         tx_prev;
    logic [NUM_CH-1:0]         rx_prev;
    chan_out_t [NUM_CH-1:0]    ch;
  } port_state_s_t;

  port_state_s_t s_q;
  port_state_s_t s_d;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // The whole port is one struct so that every output leaves a flop.
  always_comb
  begin
    logic rd_stb;
    logic wr_stb;
    logic mux_mode;
    logic ptr_mode;
    logic sel;
    logic ack_cycle;
    logic [ADDR_W-1:0] addr;
    logic [1:0] be;
    s_d = s_q;
    s_d.req.valid = 1'b0;
    rd_stb = ~host_ctrl.rd_n | (~host_ctrl.ds_n & host_ctrl.rw);
    wr_stb = ~host_ctrl.wr_n | (~host_ctrl.ds_n & ~host_ctrl.rw);
    mux_mode = (s_q.mode == MODE_MUX16) | (s_q.mode == MODE_MUX8) | (s_q.mode == MODE_MUX8A);
    ptr_mode = (s_q.mode == MODE_NMUX16) | (s_q.mode == MODE_NMUX8);
    ack_cycle = ~host_ctrl.intack_n & rd_stb;
    sel = mux_mode ? s_q.mux_cs : ~host_ctrl.cs_n;
    addr = s_q.ptr;
    be = BE_LOW;

    // Address strobe rise latches the address and the chip select
    s_d.as_prev = host_ctrl.as_n;
    if (mux_mode && !s_q.as_prev && host_ctrl.as_n)
    begin
      s_d.mux_addr = host_bus_in[ADDR_W-1:0];
      s_d.mux_cs = ~host_ctrl.cs_n;
    end

    // Address source and byte lanes per bus mode
    unique case (s_q.mode)
      MODE_NMUX16: begin addr = s_q.ptr; be = BE_BOTH; end
      MODE_NMUX8: begin addr = s_q.ptr; be = BE_LOW; end
      MODE_NMUX8A: begin addr = host_bus_in[15:8]; be = BE_LOW; end
      MODE_MUX16: begin addr = s_q.mux_addr; be = BE_BOTH; end
      MODE_MUX8: begin addr = s_q.mux_addr; be = BE_LOW; end
      MODE_MUX8A: begin addr = host_bus_in[15:8]; be = BE_LOW; end
      default: begin addr = s_q.ptr; be = BE_LOW; end
    endcase

    unique case (s_q.st)
      ST_IDLE:
      begin
        if (!s_q.cfg_done && wr_stb && sel)
        begin
          // First write only configures; it never reaches the core
          s_d.cfg_done = 1'b1;
          s_d.mode = bus_mode_t'(host_bus_in[CFG_MODE_LSB +: CFG_MODE_W]);
          s_d.wait_sense = host_ctrl.chan_sel;
          s_d.st = ST_DONE;
        end
        else if (s_q.cfg_done && ptr_mode && wr_stb && sel && host_ctrl.ptr_sel && !host_ctrl.data_ctrl)
        begin
          s_d.ptr = host_bus_in[ADDR_W-1:0];
          s_d.st = ST_DONE;
        end
        else if (s_q.cfg_done && (ack_cycle || ((rd_stb || wr_stb) && sel)))
        begin
          s_d.req.valid = 1'b1;
          s_d.req.write = wr_stb & ~ack_cycle;
          s_d.req.intack = ack_cycle;
          s_d.req.chan_sel = host_ctrl.chan_sel;
          s_d.req.data_ctrl = host_ctrl.data_ctrl;
          s_d.req.addr = addr;
          s_d.req.wdata = {host_bus_in[15:8] & {8{be[1]}}, host_bus_in[7:0]}; // Upper lanes ignored in 8-bit
          s_d.req.be = be;
          s_d.is_read = ~s_d.req.write;
          s_d.be = be;
          s_d.st = ST_BUSY;
        end
      end
      ST_BUSY:
      begin
        if (reg_ack)
        begin
          if (s_q.is_read)
          begin
            s_d.bus_out = {reg_rdata[15:8] & {8{s_q.be[1]}}, reg_rdata[7:0]};
            s_d.bus_oe = s_q.be;
          end
          s_d.st = ST_DONE;
        end
      end
      ST_DONE:
      begin
        // Hold data until the host lets go of the read and write strobes
        if (!rd_stb && !wr_stb)
        begin
          s_d.bus_oe = BE_NONE;
          s_d.st = ST_IDLE;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase

    // Wait holds the host off while busy; ready marks completion
    if (s_q.wait_sense)
      s_d.wait_rdy_n = ~(s_d.st == ST_BUSY);
    else
      s_d.wait_rdy_n = ~(s_d.st == ST_DONE);

    // Per-channel pins
    for (int i = 0; i < NUM_CH; i++)
    begin
      s_d.ch[i].irq_request_n = ~chan_in[i].irq_pending;
      s_d.ch[i].chain_enable_out = chan_in[i].chain_enable_in & ~chan_in[i].in_service
                                   & ~(chan_in[i].irq_pending & ~host_ctrl.intack_n);
      s_d.tx_prev[i] = chan_in[i].tx_flyby_ack_n;
      s_d.rx_prev[i] = chan_in[i].rx_flyby_ack_n;
      // Falling edge of an acknowledge pin is one fly-by transfer
      s_d.ch[i].tx_fifo_wr = ~chan_in[i].ack_gpio_mode & s_q.tx_prev[i] & ~chan_in[i].tx_flyby_ack_n;
      s_d.ch[i].rx_fifo_rd = ~chan_in[i].ack_gpio_mode & s_q.rx_prev[i] & ~chan_in[i].rx_flyby_ack_n;
      s_d.ch[i].tx_ack_out = chan_in[i].tx_gpio_out;
      s_d.ch[i].tx_ack_oe = chan_in[i].ack_gpio_mode & chan_in[i].tx_gpio_oe;
      s_d.ch[i].rx_ack_out = chan_in[i].rx_gpio_out;
      s_d.ch[i].rx_ack_oe = chan_in[i].ack_gpio_mode & chan_in[i].rx_gpio_oe;
      s_d.ch[i].tx_gpio_in = chan_in[i].tx_flyby_ack_n;
      s_d.ch[i].rx_gpio_in = chan_in[i].rx_flyby_ack_n;
      s_d.ch[i].serial_out = chan_in[i].tx_bit;
      s_d.ch[i].serial_oe = chan_in[i].tx_enable;
      s_d.ch[i].rx_bit = chan_in[i].serial_in;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Reset leaves the bus undriven and the handshake inactive.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_q <= '0;
      s_q.mode <= MODE_NMUX16;
      s_q.as_prev <= 1'b1;
      s_q.wait_rdy_n <= 1'b1;
      s_q.tx_prev <= '1;
      s_q.rx_prev <= '1;
      for (int i = 0; i < NUM_CH; i++)
      begin
        s_q.ch[i].irq_request_n <= 1'b1;
      end
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state flops
  assign host_bus_out = s_q.bus_out;
  assign host_bus_oe = s_q.bus_oe;
  assign wait_rdy_n = s_q.wait_rdy_n;
  assign core_req = s_q.req;
  assign chan_out = s_q.ch;

endmodule

// ===== design/host_port_pkg.sv
// Package: constants, modes and carrier structs of the host bus port.
// Assumes one 100 MHz clock; all pin inputs arrive synchronous to it.
package host_port_pkg;

  localparam int NUM_CH = 2;                       // Channels A and B
  localparam int DATA_W = 16;                      // Full host bus width
  localparam int ADDR_W = 8;                       // Register address width
  localparam int CFG_MODE_LSB = 0;                 // Bus mode field in config data
  localparam int CFG_MODE_W = 3;
  localparam logic [1:0] BE_LOW = 2'h1;            // Byte lanes used by 8-bit modes
  localparam logic [1:0] BE_BOTH = 2'h3;           // Byte lanes used by 16-bit modes
  localparam logic [1:0] BE_NONE = 2'h0;

  // --------------------------------------------------------------
  // Bus modes, as encoded in the configuration write
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_NMUX16 = 3'b000,   // 16-bit data, pointer addressing
    MODE_NMUX8  = 3'b001,   // 8-bit data, pointer addressing
    MODE_NMUX8A = 3'b010,   // 8-bit data, address on upper lines
    MODE_MUX16  = 3'b011,   // Address latched from low lines, 16-bit data
    MODE_MUX8   = 3'b100,   // Address and data on low lines
    MODE_MUX8A  = 3'b101    // 8-bit data, address on upper lines
  } bus_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,        // Waiting for a strobe
    ST_BUSY = 2'b01,        // Request out, waiting for the core
    ST_DONE = 2'b10         // Transfer finished, waiting for strobe release
  } port_state_t;

  // --------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------
  typedef struct packed {
    logic cs_n;             // Chip select
    logic as_n;             // Address strobe, multiplexed modes only
    logic ds_n;             // Data strobe, direction from rw
    logic rw;               // High reads with ds_n
    logic rd_n;             // Read strobe
    logic wr_n;             // Write strobe
    logic chan_sel;         // Channel select, high is channel A
    logic data_ctrl;        // High accesses the data registers directly
    logic ptr_sel;          // High on a write loads the address pointer
    logic intack_n;         // Interrupt acknowledge cycle in progress
  } host_ctrl_t;

  typedef struct packed {
    logic              valid;     // One-cycle request pulse
    logic              write;     // Write when high
    logic              intack;    // Vector fetch
    logic              chan_sel;  // Channel addressed
    logic              data_ctrl; // Direct data register access
    logic [ADDR_W-1:0] addr;      // Register address
    logic [DATA_W-1:0] wdata;     // Write data, unused lanes zero
    logic [1:0]        be;        // Byte lanes in use
  } core_req_t;

  typedef struct packed {
    logic irq_pending;      // Interrupt condition pending
    logic in_service;       // Interrupt under service
    logic chain_enable_in;  // Daisy-chain enable from upstream
    logic tx_flyby_ack_n;   // Transmit acknowledge pin level
    logic rx_flyby_ack_n;   // Receive acknowledge pin level
    logic ack_gpio_mode;    // Acknowledge pins used as bit I/O
    logic tx_gpio_out;      // Bit output on transmit acknowledge pin
    logic tx_gpio_oe;
    logic rx_gpio_out;      // Bit output on receive acknowledge pin
    logic rx_gpio_oe;
    logic tx_bit;           // Transmit serial bit from the engine
    logic tx_enable;        // Transmit pin driven when high
    logic serial_in;        // Receive data pin
  } chan_in_t;

  typedef struct packed {
    logic irq_request_n;    // Active-low interrupt request
    logic chain_enable_out; // Daisy-chain enable to downstream
    logic tx_ack_out;
    logic tx_ack_oe;
    logic rx_ack_out;
    logic rx_ack_oe;
    logic tx_fifo_wr;       // Fly-by write strobe, one cycle
    logic rx_fifo_rd;       // Fly-by read strobe, one cycle
    logic tx_gpio_in;       // Pin level for bit-input use
    logic rx_gpio_in;
    logic serial_out;       // Transmit data pin
    logic serial_oe;
    logic rx_bit;           // Received bit to the engine
  } chan_out_t;

endpackage

// ===== testbench/host_port_asserts.sv
// Checker: port-level timing properties of the host bus port.
// Assumes it is bound to host_bus_port_daisy_chain and sees only its ports.
`timescale 1ns/1ps
module host_port_asserts
  import host_port_pkg::*;
(
  input wire logic                   clk,          // Clock
  input wire logic                   srst,         // Reset
  input wire host_ctrl_t             host_ctrl,    // Host strobes
  input wire logic [DATA_W-1:0]      host_bus_in,  // Bus level
  input wire logic [DATA_W-1:0]      host_bus_out, // Read data
  input wire logic [1:0]             host_bus_oe,  // Lane enables
  input wire logic                   wait_rdy_n,   // Wait or ready
  input wire core_req_t              core_req,     // Core request
  input wire logic                   reg_ack,      // Core done
  input wire logic [DATA_W-1:0]      reg_rdata,    // Core data
  input wire chan_in_t  [NUM_CH-1:0] chan_in,      // Channel inputs
  input wire chan_out_t [NUM_CH-1:0] chan_out      // Channel outputs
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic rd_act;
  logic up_q;
  // Outputs lag inputs by one edge, so the first edge after reset is skipped
  always_ff @(posedge clk) up_q <= !srst;
  assign rd_act = !host_ctrl.rd_n || (!host_ctrl.ds_n && host_ctrl.rw);

  a_irq_level: assert property (up_q |-> chan_out[1].irq_request_n == !$past(chan_in[1].irq_pending))
    else $error("irq request level wrong");
  a_chain_block: assert property (up_q |-> chan_out[1].chain_enable_out == $past(chan_in[1].chain_enable_in
    && !chan_in[1].in_service && !(chan_in[1].irq_pending && !host_ctrl.intack_n))) else $error("chain out wrong");
  a_serial_path: assert property (up_q |-> chan_out[0].serial_out == $past(chan_in[0].tx_bit)
    && chan_out[0].serial_oe == $past(chan_in[0].tx_enable) && chan_out[1].rx_bit == $past(chan_in[1].serial_in))
    else $error("serial path wrong");
  a_flyby_tx: assert property (up_q && $fell(chan_in[0].tx_flyby_ack_n) && !chan_in[0].ack_gpio_mode
    |=> chan_out[0].tx_fifo_wr ##1 !chan_out[0].tx_fifo_wr) else $error("tx strobe missing");
  a_gpio_no_rd: assert property (up_q && $fell(chan_in[1].rx_flyby_ack_n) && chan_in[1].ack_gpio_mode
    |=> !chan_out[1].rx_fifo_rd) else $error("rx strobe in bit mode");
  a_bus_release: assert property (!rd_act |=> host_bus_oe == BE_NONE) else $error("bus driven idle");
  a_req_pulse: assert property (core_req.valid |=> !core_req.valid) else $error("request not a pulse");
  a_wait_drop: assert property (reg_ack && !wait_rdy_n |=> wait_rdy_n) else $error("wait not released");
  a_ready_ack: assert property (reg_ack && wait_rdy_n |=> !wait_rdy_n) else $error("ready missing");
  c_wait: cover property (reg_ack && !wait_rdy_n);
  c_ready: cover property (reg_ack && wait_rdy_n);
  c_flyby: cover property (chan_out[0].tx_fifo_wr);
  c_vector: cover property (core_req.valid && core_req.intack);
endmodule

// ===== testbench/core_model.sv
// Register core model: answers each request after a set latency.
// Assumes core_req.valid is a one-cycle pulse; data lines invert when idle.
`timescale 1ns/1ps
module core_model
  import host_port_pkg::*;
(
  input  wire logic              clk,       // Clock
  input  wire logic              srst,      // Reset
  input  wire core_req_t         core_req,  // Request in
  input  wire logic [3:0]        lat,       // Extra wait cycles
  input  wire logic [DATA_W-1:0] rdata_val, // Data to return
  output logic                   reg_ack,   // Done pulse
  output logic [DATA_W-1:0]      reg_rdata  // Returned data
);
  logic       busy_q;
  logic [3:0] cnt_q;
  // Inverse pattern off the ack so stale data cannot pass for good data
  assign reg_rdata = reg_ack ? rdata_val : ~rdata_val;
  // Latency counter
  always_ff @(posedge clk)
    if (srst)
    begin
      busy_q  <= 1'b0;
      reg_ack <= 1'b0;
      cnt_q   <= 4'h0;
    end
    else
    begin
      reg_ack <= 1'b0;
      if (core_req.valid)
      begin
        busy_q <= 1'b1;
        cnt_q  <= lat;
      end
      else if (busy_q && cnt_q == 4'h0)
      begin
        reg_ack <= 1'b1;
        busy_q  <= 1'b0;
      end
      else if (busy_q)
        cnt_q <= cnt_q - 4'h1;
    end
endmodule

// ===== testbench/tb.sv
// Testbench: bus modes, wait/ready sense, chain, fly-by and serial pins.
// Assumes core_model answers requests; inputs change at the falling edge.
`timescale 1ns/1ps
module tb;
  import host_port_pkg::*;
  typedef struct packed {logic [2:0] m; logic s; logic [3:0] lat; logic [7:0] a; logic [15:0] d, r;} row_t;
  logic clk, srst, reg_ack, cur_s, mux, sep, b16, wait_rdy_n;
  logic [3:0] lat;
  logic [15:0] bin, bout, rdv, rdata, got, mask;
  logic [1:0] boe, gotoe, be;
  host_ctrl_t hc;
  core_req_t creq;
  chan_in_t [1:0] ci;
  chan_out_t [1:0] co;
  int n_fail, tests_run, n_req, n_txw, n_rxr, cyc_n, n0, i, k;
  row_t r;
  row_t rows [6] = '{'{3'h0, 1'b1, 4'h0, 8'h21, 16'ha5c3, 16'h1357}, '{3'h1, 1'b0, 4'h3, 8'h42, 16'h5a3c, 16'h2468},
    '{3'h2, 1'b1, 4'h1, 8'h63, 16'hc396, 16'h369c}, '{3'h3, 1'b0, 4'h5, 8'h84, 16'h6c93, 16'h48ac},
    '{3'h4, 1'b1, 4'h2, 8'ha5, 16'h9669, 16'h5ace}, '{3'h5, 1'b0, 4'h4, 8'hc6, 16'h33cc, 16'h6b0f}};

  host_bus_port_daisy_chain uut (.clk(clk), .srst(srst), .host_ctrl(hc), .host_bus_in(bin), .host_bus_out(bout),
    .host_bus_oe(boe), .wait_rdy_n(wait_rdy_n), .core_req(creq), .reg_ack(reg_ack), .reg_rdata(rdata),
    .chan_in(ci), .chan_out(co));
  core_model u_core (.clk(clk), .srst(srst), .core_req(creq), .lat(lat), .rdata_val(rdv), .reg_ack(reg_ack),
    .reg_rdata(rdata));

  task automatic give_verdict;
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // One host cycle; with fwd set the strobe holds until the handshake shows completion, else for three cycles
  task automatic cyc(input logic w, input logic m, input logic fwd, input logic [15:0] d);
    int j;
    logic low;
    @(negedge clk);
    bin = d;
    hc.cs_n = 1'b0;
    low = 1'b0;
    if (m)
      {hc.ds_n, hc.rw} = {1'b0, !w};
    else if (w)
      hc.wr_n = 1'b0;
    else
      hc.rd_n = 1'b0;
    for (j = 0; j < 40; j++)
    begin
      @(negedge clk);
      if (!wait_rdy_n)
        low = 1'b1;
      if (!fwd ? j == 2 : (cur_s ? low && wait_rdy_n : !wait_rdy_n))
        break;
    end
    // A handshake that never completes counts as a mismatch
    if (j == 40)
      chk(16'h0, 16'h1);
    {got, gotoe} = {bout, boe};
    {hc.rd_n, hc.wr_n, hc.ds_n, hc.cs_n, hc.intack_n, hc.ptr_sel} = 6'h3e;
    repeat (2) @(negedge clk);
  endtask
  // Address phase of the multiplexed modes; cs is latched as as_n rises
  task automatic aph(input logic [7:0] a, input logic cs);
    @(negedge clk);
    {hc.cs_n, hc.as_n, bin} = {!cs, 1'b0, 8'h00, a};
    @(negedge clk);
    hc.as_n = 1'b1;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Event counters and the hang limit
  always @(posedge clk)
  begin
    cyc_n++;
    n_req += creq.valid;
    n_txw += co[0].tx_fifo_wr;
    n_rxr += co[1].rx_fifo_rd;
    if (cyc_n == 20000)
    begin
      n_fail++;
      give_verdict();
    end
  end

  initial
  begin
    {hc, bin, lat, rdv, cur_s, srst} = {10'h3b1, 16'h0, 4'h0, 16'h0, 1'b0, 1'b1};
    ci = '0;
    {ci[0].tx_flyby_ack_n, ci[0].rx_flyby_ack_n, ci[1].tx_flyby_ack_n, ci[1].rx_flyby_ack_n} = 4'hf;
    for (i = 0; i < 6; i++)
    begin
      r = rows[i];
      srst = 1'b1;
      cur_s = 1'b0;
      repeat (16) @(negedge clk);
      chk({boe, wait_rdy_n, co[0].irq_request_n}, 4'h3);
      srst = 1'b0;
      n0 = n_req;
      cyc(0, 0, 0, 16'h0);
      hc.chan_sel = r.s;
      cyc(1, 0, 0, {13'h0, r.m});
      chk(16'(n_req), 16'(n0));
      {cur_s, lat, rdv} = {r.s, r.lat, r.r};
      mux = r.m == MODE_MUX16 || r.m == MODE_MUX8 || r.m == MODE_MUX8A;
      sep = r.m == MODE_NMUX8A || r.m == MODE_MUX8A;
      b16 = r.m == MODE_NMUX16 || r.m == MODE_MUX16;
      {be, mask} = b16 ? {BE_BOTH, 16'hffff} : {BE_LOW, 16'h00ff};
      hc.ptr_sel = !mux && !sep;
      if (!mux && !sep)
        cyc(1, 0, 0, {8'h0, r.a});
      if (mux)
        aph(r.a, 1'b1);
      cyc(1, mux, 1, sep ? {r.a, r.d[7:0]} : r.d);
      chk({creq.addr, creq.be, creq.write}, {r.a, be, 1'b1});
      chk(creq.wdata, r.d & mask);
      chk({creq.chan_sel, creq.data_ctrl}, {r.s, 1'b0});
      chk(16'(n_req - n0), 16'h1);
      if (mux)
        aph(r.a, 1'b1);
      cyc(0, mux, 1, sep ? {r.a, 8'h00} : 16'h0);
      chk(got, r.r & mask);
      chk({gotoe, creq.addr, creq.write}, {be, r.a, 1'b0});
    end
    // Unselected multiplexed cycle is ignored
    aph(8'h11, 1'b0);
    n0 = n_req;
    // Let the deselect latch before the strobe comes
    @(negedge clk);
    hc.rd_n = 1'b0;
    repeat (4) @(negedge clk);
    hc.rd_n = 1'b1;
    chk(16'(n_req), 16'(n0));
    // Vector fetch needs no select
    hc.intack_n = 1'b0;
    cyc(0, 0, 1, 16'h0);
    chk({creq.intack, got}, {1'b1, rdv & 16'h00ff});
    for (k = 0; k < 16; k++)
    begin
      {hc.intack_n, ci[1].irq_pending, ci[1].in_service, ci[1].chain_enable_in} = k[3:0];
      repeat (2) @(negedge clk);
      chk(co[1].chain_enable_out, k[0] & !k[1] & !(k[2] & !k[3]));
      chk(co[1].irq_request_n, !k[2]);
    end
    // Fly-by strobes, bit mode on the receive pin, and serial pins
    {ci[0].tx_flyby_ack_n, ci[1].ack_gpio_mode, ci[1].rx_flyby_ack_n, hc.intack_n} = 4'h5;
    {ci[0].tx_bit, ci[0].tx_enable, ci[1].serial_in} = 3'h7;
    {ci[0].tx_gpio_oe, ci[1].rx_gpio_out, ci[1].rx_gpio_oe, ci[1].tx_gpio_oe, ci[1].tx_gpio_out} = 5'h1f;
    repeat (3) @(negedge clk);
    chk({n_txw[3:0], n_rxr[3:0]}, 8'h10);
    chk({co[0].serial_out, co[0].serial_oe, co[1].rx_bit}, 3'h7);
    // Bit I/O drives only in bit mode; the pin levels read back
    chk({co[0].tx_ack_oe, co[1].rx_ack_oe, co[1].rx_ack_out, co[1].tx_ack_oe, co[1].tx_ack_out, co[1].rx_gpio_in,
      co[1].tx_gpio_in, co[0].tx_gpio_in}, 8'h7a);
    give_verdict();
  end
endmodule

bind host_bus_port_daisy_chain host_port_asserts u_chk (.clk(clk), .srst(srst), .host_ctrl(host_ctrl),
  .host_bus_in(host_bus_in), .host_bus_out(host_bus_out), .host_bus_oe(host_bus_oe), .wait_rdy_n(wait_rdy_n),
  .core_req(core_req), .reg_ack(reg_ack), .reg_rdata(reg_rdata), .chan_in(chan_in), .chan_out(chan_out));
